// *** hdl/lsm_consts.svh ***
// constants for the line signal monitor and transmit shaper control
`ifndef LSM_CONSTS_SVH
`define LSM_CONSTS_SVH
// ************************************************
// register offsets
// ************************************************
`define LSM_A_CFG 5'h00
`define LSM_A_CHIDX 5'h01
`define LSM_A_TCODE 5'h02
`define LSM_A_LOS_STAT 5'h03
`define LSM_A_LOS_LAT 5'h04
`define LSM_A_LOS_MASK 5'h05
`define LSM_A_DF_STAT 5'h06
`define LSM_A_DF_LAT 5'h07
`define LSM_A_DF_MASK 5'h08
`define LSM_A_MODE_STAT 5'h09
// ************************************************
// field positions, reset values and template codes
// ************************************************
`define LSM_CFG_SG_BIT 0
`define LSM_CFG_CRIT_LSB 1
`define LSM_CFG_RST 8'h00
`define LSM_MASK_RST 8'hFF
`define LSM_TMPL_RST 3'h0
`define LSM_TMPL_E1 3'h0
`define LSM_TMPL_T1_MIN 3'h3
// ************************************************
// loss of signal counts, in bit periods, and mark counts
// ************************************************
`define LSM_T1_ZRUN 12'h0AF
`define LSM_G775_ZRUN 12'h020
`define LSM_ETSI_ZRUN 12'h800
`define LSM_T1_MARKS 8'h10
`define LSM_E1_MARKS 8'h04
`define LSM_T1_ZLIM 12'h063
`define LSM_E1_ZLIM 12'h00F
`define LSM_T1_WIN 8'h80
`define LSM_E1_WIN 8'h20
`endif

// *** hdl/lsm_pkg.sv ***
// types for the line signal monitor and transmit shaper control
package lsm_pkg;
   // loss of signal criterion
   typedef enum logic [1:0] {LSM_CRIT_T1 = 2'h0, LSM_CRIT_G775 = 2'h1, LSM_CRIT_ETSI = 2'h3} lsm_crit_t;
   // detector state
   typedef enum logic {LSM_LS_OK = 1'h0, LSM_LS_LOST = 1'h1} lsm_los_state_t;
endpackage : lsm_pkg

// *** hdl/lsm_sync.sv ***
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module lsm_sync #(
   parameter int W = 8
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // first stage feeds only the second
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : lsm_sync

// *** hdl/lsm_los_det.sv ***
// loss of signal detector for one receive channel
`timescale 1ns/1ps
`include "lsm_consts.svh"
module lsm_los_det (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // receive
   input wire logic bit_tick,
   input wire logic slice_any,
   input wire logic amp_low,
   input wire lsm_pkg::lsm_crit_t crit,
   // result
   output logic los
);
   logic mark_seen;
   logic mark_bit;
   logic [11:0] zero_run;
   logic [11:0] next_zero_run;
   logic [127:0] window;
   logic [7:0] cnt128;
   logic [7:0] cnt32;
   logic [7:0] guard;
   logic [11:0] thresh;
   logic [11:0] zlim;
   logic [7:0] need;
   logic [7:0] cnt_sel;
   logic [7:0] guard_len;
   lsm_pkg::lsm_los_state_t state;

   // criterion figures
   always_comb
   begin
      mark_bit = mark_seen | slice_any;
      next_zero_run = mark_bit ? 12'h000 : ((zero_run == 12'hFFF) ? zero_run : zero_run + 12'h001);
      case (crit)
         lsm_pkg::LSM_CRIT_T1:
         begin
            thresh = `LSM_T1_ZRUN;
            zlim = `LSM_T1_ZLIM;
            need = `LSM_T1_MARKS;
            cnt_sel = cnt128;
            guard_len = `LSM_T1_WIN;
         end
         lsm_pkg::LSM_CRIT_ETSI:
         begin
            thresh = `LSM_ETSI_ZRUN;
            zlim = `LSM_E1_ZLIM;
            need = `LSM_E1_MARKS;
            cnt_sel = cnt32;
            guard_len = `LSM_E1_WIN;
         end
         default:
         begin
            thresh = `LSM_G775_ZRUN;
            zlim = `LSM_E1_ZLIM;
            need = `LSM_E1_MARKS;
            cnt_sel = cnt32;
            guard_len = `LSM_E1_WIN;
         end
      endcase
   end

   // mark catch within one bit period
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         mark_seen <= 1'b0;
      else if (ce)
         mark_seen <= bit_tick ? 1'b0 : (mark_seen | slice_any);
   end

   // zero run, density window and long-run guard
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         zero_run <= 12'h000;
         window <= '0;
         cnt128 <= 8'h00;
         cnt32 <= 8'h00;
         guard <= 8'h00;
      end
      else if (ce && bit_tick)
      begin
         zero_run <= next_zero_run;
         window <= {window[126:0], mark_bit};
         cnt128 <= cnt128 + {7'h00, mark_bit} - {7'h00, window[127]};
         cnt32 <= cnt32 + {7'h00, mark_bit} - {7'h00, window[31]};
         if (next_zero_run > zlim)
            guard <= guard_len;
         else if (guard != 8'h00)
            guard <= guard - 8'h01;
      end
   end

   // declare and clear
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= lsm_pkg::LSM_LS_OK;
      else if (ce)
      begin
         case (state)
            lsm_pkg::LSM_LS_OK:
               if (amp_low || (bit_tick && next_zero_run >= thresh))
                  state <= lsm_pkg::LSM_LS_LOST;
            lsm_pkg::LSM_LS_LOST:
               if (bit_tick && !amp_low && cnt_sel >= need && guard == 8'h00
                   && !(next_zero_run > zlim))
                  state <= lsm_pkg::LSM_LS_OK;
            default:
               state <= lsm_pkg::LSM_LS_OK;
         endcase
      end
   end

   assign los = (state == lsm_pkg::LSM_LS_LOST);

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   zero_run_decl_a: assert property (ce && bit_tick && !mark_bit && zero_run == thresh - 12'h001 |=> los)
      else $error("zero run did not declare loss");
   amp_decl_a: assert property (ce && amp_low |=> los)
      else $error("low amplitude did not declare loss");
   density_clear_a: assert property ($fell(los) |-> $past(cnt_sel >= need && guard == 8'h00))
      else $error("loss cleared without density");
   run_restart_a: assert property (ce && bit_tick && mark_bit |=> zero_run == 12'h000)
      else $error("zero run not restarted by mark");
   los_rise_c: cover property ($rose(los));
   los_fall_c: cover property ($fell(los));
endmodule : lsm_los_det

// *** hdl/lsm_top.sv ***
// eight channel line signal monitor, transmit latch and shaper control
// ************************************************
// ************************************************
`timescale 1ns/1ps
`include "lsm_consts.svh"
module lsm_top #(
   parameter int NCH = 8
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // mode pins
   input wire logic hw_mode_pin,
   input wire logic [2:0] template_code_pin,
   input wire logic mclk_present,
   // receive side from slicers
   input wire logic [NCH-1:0] pos_slice_in,
   input wire logic [NCH-1:0] neg_slice_in,
   input wire logic [NCH-1:0] rx_bit_clk,
   input wire logic [NCH-1:0] amp_low_in,
   // receive side to framer
   output logic [NCH-1:0] pos_slice_out,
   output logic [NCH-1:0] neg_slice_out,
   output logic [NCH-1:0] rail_xor_out,
   output logic [NCH-1:0] no_signal_pin,
   // transmit side
   input wire logic [NCH-1:0] tx_line_clock,
   input wire logic [NCH-1:0] tx_pos_rail,
   input wire logic [NCH-1:0] tx_neg_rail,
   output logic [NCH-1:0] line_drive_pos,
   output logic [NCH-1:0] line_drive_neg,
   // shaper control
   output logic [NCH-1:0][2:0] template_sel,
   output logic shaper_bypass,
   // driver fault
   input wire logic [NCH-1:0] driver_fault_monitor,
   output logic short_guard_enable,
   output logic int_b
);
   localparam int SW = 5 + 8 * NCH;
   logic [SW-1:0] sync_q;
   logic hw_s;
   logic [2:0] code_s;
   logic mclk_s;
   logic [NCH-1:0] pos_s, neg_s, rxclk_s, amp_s, txclk_s, txp_s, txn_s, short_s;
   logic [NCH-1:0] rxclk_d, txclk_d, tx_fall, det_los;
   logic [7:0] global_config, template_chan_index;
   logic [NCH-1:0] los_latched, los_mask;
   logic [NCH-1:0] driver_fault_status, driver_fault_latched, driver_fault_mask;
   logic [NCH-1:0] los_clr, df_clr;
   logic [7:0] rd_mux;
   lsm_pkg::lsm_crit_t crit;

   // a template code outside the reserved pair
   function automatic logic tmpl_ok(input logic [2:0] code);
      tmpl_ok = (code == `LSM_TMPL_E1) || (code >= `LSM_TMPL_T1_MIN);
   endfunction : tmpl_ok

   // width fit of a channel vector onto the data bus
   function automatic logic [7:0] to_byte(input logic [NCH-1:0] v);
      to_byte = 8'(v);
   endfunction : to_byte

   // ************************************************
   // input synchronisers
   // ************************************************
   lsm_sync #(.W(SW)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .d({hw_mode_pin, template_code_pin, mclk_present, amp_low_in, rx_bit_clk, driver_fault_monitor,
          tx_neg_rail, tx_pos_rail, tx_line_clock, neg_slice_in, pos_slice_in}),
      .q(sync_q)
   );

   // unpack synchronised levels
   assign {hw_s, code_s, mclk_s, amp_s, rxclk_s, short_s, txn_s, txp_s, txclk_s, neg_s, pos_s} = sync_q;

   // edge history for bit and transmit clocks
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rxclk_d <= '0;
         txclk_d <= '0;
      end
      else if (ce)
      begin
         rxclk_d <= rxclk_s;
         txclk_d <= txclk_s;
      end
   end

   assign tx_fall = txclk_d & ~txclk_s;

   // ************************************************
   // receive path
   // ************************************************
   // slice pass-through and xor clock, never squelched
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pos_slice_out <= '0;
         neg_slice_out <= '0;
         rail_xor_out <= '0;
      end
      else if (ce)
      begin
         pos_slice_out <= pos_s;
         neg_slice_out <= neg_s;
         rail_xor_out <= pos_s ^ neg_s;
      end
   end

   // criterion: host from config, hardware from template family
   always_comb
   begin
      if (hw_s)
         crit = (code_s == `LSM_TMPL_E1) ? lsm_pkg::LSM_CRIT_G775 : lsm_pkg::LSM_CRIT_T1;
      else
      begin
         case (global_config[`LSM_CFG_CRIT_LSB +: 2])
            2'h0: crit = lsm_pkg::LSM_CRIT_T1;
            2'h2: crit = lsm_pkg::LSM_CRIT_ETSI;
            default: crit = lsm_pkg::LSM_CRIT_G775;
         endcase
      end
   end

   // one detector per channel
   for (genvar i = 0; i < NCH; i++)
   begin : g_det
      lsm_los_det u_det (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .ce(ce),
         .bit_tick(rxclk_s[i] & ~rxclk_d[i]),
         .slice_any(pos_s[i] | neg_s[i]),
         .amp_low(amp_s[i]),
         .crit(crit),
         .los(det_los[i])
      );
   end

   // clear strobes, write one to clear
   assign los_clr = (reg_wr && reg_addr == `LSM_A_LOS_LAT) ? NCH'(reg_wdata) : '0;
   assign df_clr = (reg_wr && reg_addr == `LSM_A_DF_LAT) ? NCH'(reg_wdata) : '0;

   // loss status pin and sticky change latch, set beats clear
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         no_signal_pin <= '0;
         los_latched <= '0;
      end
      else if (ce)
      begin
         no_signal_pin <= det_los;
         los_latched <= (los_latched & ~los_clr) | (det_los ^ no_signal_pin);
      end
   end

   // ************************************************
   // transmit path
   // ************************************************
   // rails captured on falling transmit clock edge
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         line_drive_pos <= '0;
         line_drive_neg <= '0;
      end
      else if (ce)
      begin
         line_drive_pos <= (line_drive_pos & ~tx_fall) | (txp_s & tx_fall);
         line_drive_neg <= (line_drive_neg & ~tx_fall) | (txn_s & tx_fall);
      end
   end

   // template selection, reserved codes ignored
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         template_sel <= {NCH{`LSM_TMPL_RST}};
      else if (ce)
      begin
         if (hw_s)
         begin
            if (tmpl_ok(code_s))
               template_sel <= {NCH{code_s}};
         end
         else if (reg_wr && reg_addr == `LSM_A_TCODE && tmpl_ok(reg_wdata[2:0]))
            template_sel[template_chan_index[2:0]] <= reg_wdata[2:0];
      end
   end

   // shaper bypass set while the reference clock is absent
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         shaper_bypass <= 1'b1;
      else if (ce)
         shaper_bypass <= ~mclk_s;
   end

   // ************************************************
   // driver fault
   // ************************************************
   // status follows monitor, latch sticky, both gated by guard
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         driver_fault_status <= '0;
         driver_fault_latched <= '0;
      end
      else if (ce)
      begin
         if (!short_guard_enable)
         begin
            driver_fault_status <= '0;
            driver_fault_latched <= '0;
         end
         else
         begin
            driver_fault_status <= short_s;
            driver_fault_latched <= (driver_fault_latched & ~df_clr) | short_s;
         end
      end
   end

   // masked interrupt, active low
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         int_b <= 1'b1;
      else if (ce)
         int_b <= ~(|(los_latched & ~los_mask) | |(driver_fault_latched & ~driver_fault_mask));
   end

   // ************************************************
   // register port
   // ************************************************
   // writable registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         global_config <= `LSM_CFG_RST;
         template_chan_index <= 8'h00;
         los_mask <= NCH'(`LSM_MASK_RST);
         driver_fault_mask <= NCH'(`LSM_MASK_RST);
         short_guard_enable <= 1'b0;
      end
      else if (ce && reg_wr)
      begin
         case (reg_addr)
            `LSM_A_CFG:
            begin
               global_config <= {5'h00, reg_wdata[2:0]};
               short_guard_enable <= reg_wdata[`LSM_CFG_SG_BIT];
            end
            `LSM_A_CHIDX: template_chan_index <= {5'h00, reg_wdata[2:0]};
            `LSM_A_LOS_MASK: los_mask <= NCH'(reg_wdata);
            `LSM_A_DF_MASK:
               if (short_guard_enable)
                  driver_fault_mask <= NCH'(reg_wdata);
            default: ;
         endcase
      end
   end

   // read selection
   always_comb
   begin
      case (reg_addr)
         `LSM_A_CFG: rd_mux = global_config;
         `LSM_A_CHIDX: rd_mux = template_chan_index;
         `LSM_A_TCODE: rd_mux = {5'h00, template_sel[template_chan_index[2:0]]};
         `LSM_A_LOS_STAT: rd_mux = to_byte(no_signal_pin);
         `LSM_A_LOS_LAT: rd_mux = to_byte(los_latched);
         `LSM_A_LOS_MASK: rd_mux = to_byte(los_mask);
         `LSM_A_DF_STAT: rd_mux = to_byte(driver_fault_status);
         `LSM_A_DF_LAT: rd_mux = to_byte(driver_fault_latched);
         `LSM_A_DF_MASK: rd_mux = short_guard_enable ? to_byte(driver_fault_mask) : 8'h00;
         `LSM_A_MODE_STAT: rd_mux = {6'h00, hw_s, shaper_bypass};
         default: rd_mux = 8'h00;
      endcase
   end

   // read data stands one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else if (ce)
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   xor_clock_a: assert property (rail_xor_out == (pos_slice_out ^ neg_slice_out))
      else $error("xor clock does not match slices");
   los_pin_a: assert property (ce |=> no_signal_pin == $past(det_los))
      else $error("no-signal pin does not follow detector");
   los_change_a: assert property (ce && det_los[0] != no_signal_pin[0] |=> los_latched[0])
      else $error("loss change not latched");
   slice_during_los_a: assert property (ce && det_los[0] && pos_s[0] |=> pos_slice_out[0])
      else $error("slice squelched during loss");
   tx_sample_a: assert property (ce && tx_fall[0] |=> line_drive_pos[0] == $past(txp_s[0]))
      else $error("transmit rail not sampled on falling edge");
   hw_template_a: assert property (ce && hw_s && tmpl_ok(code_s) |=> template_sel[7] == $past(code_s))
      else $error("pin template not applied");
   bypass_mclk_a: assert property (ce && !mclk_s |=> shaper_bypass)
      else $error("shaper not bypassed without reference clock");
   guard_off_a: assert property (ce && !short_guard_enable |=> driver_fault_latched == '0)
      else $error("fault latch active with guard off");
   short_set_a: assert property (ce && short_guard_enable && short_s[0]
      |=> driver_fault_status[0] && driver_fault_latched[0])
      else $error("short not flagged");
   fault_irq_a: assert property (ce && driver_fault_latched[0] && !driver_fault_mask[0] |=> !int_b)
      else $error("unmasked fault without interrupt");
   irq_fault_c: cover property (short_guard_enable && $fell(int_b));
   los_pin_c: cover property ($rose(no_signal_pin[0]) ##[1:1000] $fell(no_signal_pin[0]));
   host_tmpl_c: cover property (!hw_s && reg_wr && reg_addr == `LSM_A_TCODE);
endmodule : lsm_top

// *** sim/lsm_framer_model.sv ***
// framer side model: transmit line clock and dual rails
`timescale 1ns/1ps
module lsm_framer_model (
   // transmit to line block
   output logic [7:0] tx_line_clock,
   output logic [7:0] tx_pos_rail,
   output logic [7:0] tx_neg_rail,
   // rails presented at the last falling edge
   output logic [7:0] sent_pos,
   output logic [7:0] sent_neg
);
   logic [7:0] cnt = 8'h00;
   // free running clock, phase unrelated to ref_clk; rails settle at its first rise, inside reset
   initial
   begin
      tx_line_clock = 8'h00;
      #37;
      forever #400 tx_line_clock = ~tx_line_clock;
   end
   // rails move on the rising edge so they stand across the falling one
   always @(posedge tx_line_clock[0])
   begin
      cnt <= cnt + 8'h01;
      tx_pos_rail <= cnt;
      tx_neg_rail <= ~cnt & 8'h5A;
   end
   // remember what was offered at the sampling edge
   always @(negedge tx_line_clock[0])
   begin
      sent_pos <= tx_pos_rail;
      sent_neg <= tx_neg_rail;
   end
endmodule : lsm_framer_model

// *** sim/tb_lsm_top.sv ***
// self-checking bench for the line signal monitor block
`timescale 1ns/1ps
`include "lsm_consts.svh"
module tb_lsm_top;
   logic ref_clk, rst_b, ce, reg_wr, reg_rd, hw_mode_pin, mclk_present, shaper_bypass, short_guard_enable, int_b;
   logic [4:0] reg_addr;
   logic [2:0] template_code_pin;
   logic [7:0] reg_wdata, reg_rdata, pos_slice_in, neg_slice_in, rx_bit_clk, amp_low_in, pos_slice_out;
   logic [7:0] neg_slice_out, rail_xor_out, no_signal_pin, tx_line_clock, tx_pos_rail, tx_neg_rail;
   logic [7:0] line_drive_pos, line_drive_neg, driver_fault_monitor, sent_pos, sent_neg;
   logic [7:0][2:0] template_sel;
   int n_fail = 0, n_checks = 0, e;
   int zr[3] = '{`LSM_T1_ZRUN, `LSM_G775_ZRUN, `LSM_ETSI_ZRUN};
   int gd[3] = '{`LSM_T1_WIN, `LSM_E1_WIN, `LSM_E1_WIN};
   logic [7:0] cf[3] = '{8'h00, 8'h02, 8'h04};
   lsm_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_mode_pin(hw_mode_pin),
      .template_code_pin(template_code_pin), .mclk_present(mclk_present), .pos_slice_in(pos_slice_in),
      .neg_slice_in(neg_slice_in), .rx_bit_clk(rx_bit_clk), .amp_low_in(amp_low_in),
      .pos_slice_out(pos_slice_out), .neg_slice_out(neg_slice_out), .rail_xor_out(rail_xor_out),
      .no_signal_pin(no_signal_pin), .tx_line_clock(tx_line_clock), .tx_pos_rail(tx_pos_rail),
      .tx_neg_rail(tx_neg_rail), .line_drive_pos(line_drive_pos), .line_drive_neg(line_drive_neg),
      .template_sel(template_sel), .shaper_bypass(shaper_bypass), .driver_fault_monitor(driver_fault_monitor),
      .short_guard_enable(short_guard_enable), .int_b(int_b));
   lsm_framer_model fr (.tx_line_clock(tx_line_clock), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail),
      .sent_pos(sent_pos), .sent_neg(sent_neg));
   // ************************************************
   // helpers
   // ************************************************
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task chk(input string n, input logic [23:0] x, input logic [23:0] s);
      n_checks++;
      if (s !== x)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [4:0] a, input logic [7:0] x);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", x, reg_rdata);
   endtask : rd
   // one bit period; optional mark in its middle on every channel
   task tick(input logic m);
      @(posedge ref_clk);
      rx_bit_clk <= 8'hFF;
      cyc(4);
      rx_bit_clk <= 8'h00;
      cyc(2);
      pos_slice_in <= {8{m}};
      cyc(2);
      pos_slice_in <= 8'h00;
   endtask : tick
   // clock and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial
   begin
      #5000000;
      n_fail++;
      stop_test();
   end
   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      {rst_b, reg_wr, reg_rd, hw_mode_pin, mclk_present, reg_addr, template_code_pin} = '0;
      {reg_wdata, pos_slice_in, neg_slice_in, rx_bit_clk, amp_low_in, driver_fault_monitor} = '0;
      ce = 1'b1;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(`LSM_A_CFG, 8'h00);
      rd(`LSM_A_LOS_MASK, 8'hFF);
      rd(`LSM_A_DF_MASK, 8'h00);
      rd(`LSM_A_MODE_STAT, 8'h01);
      rd(5'h1F, 8'h00);
      chk("int_b", 1, int_b);
      // per channel templates, reserved codes kept out
      wr(`LSM_A_CHIDX, 8'h03);
      e = 0;
      for (int k = 0; k < 8; k++)
      begin
         wr(`LSM_A_TCODE, 8'(k));
         e = (k == 1 || k == 2) ? e : k;
         rd(`LSM_A_TCODE, 8'(e));
      end
      chk("template_sel", 24'h007000 >> 3, template_sel);
      hw_mode_pin <= 1'b1;
      template_code_pin <= 3'h4;
      cyc(5);
      chk("template_sel", {8{3'h4}}, template_sel);
      rd(`LSM_A_MODE_STAT, 8'h03);
      mclk_present <= 1'b1;
      hw_mode_pin <= 1'b0;
      cyc(5);
      chk("shaper_bypass", 0, shaper_bypass);
      // driver fault with guard on, then off
      wr(`LSM_A_CFG, 8'h01);
      wr(`LSM_A_DF_MASK, 8'h00);
      chk("short_guard_enable", 1, short_guard_enable);
      driver_fault_monitor <= 8'h81;
      cyc(5);
      rd(`LSM_A_DF_STAT, 8'h81);
      rd(`LSM_A_DF_LAT, 8'h81);
      chk("int_b", 0, int_b);
      driver_fault_monitor <= 8'h00;
      cyc(5);
      rd(`LSM_A_DF_STAT, 8'h00);
      rd(`LSM_A_DF_LAT, 8'h81);
      wr(`LSM_A_DF_LAT, 8'hFF);
      cyc(3);
      chk("int_b", 1, int_b);
      wr(`LSM_A_CFG, 8'h00);
      driver_fault_monitor <= 8'hFF;
      cyc(5);
      rd(`LSM_A_DF_STAT, 8'h00);
      rd(`LSM_A_DF_LAT, 8'h00);
      driver_fault_monitor <= 8'h00;
      // transmit rails captured at falling edges
      repeat (4)
      begin
         @(negedge tx_line_clock[0]);
         cyc(6);
         chk("line_drive_pos", sent_pos, line_drive_pos);
         chk("line_drive_neg", sent_neg, line_drive_neg);
      end
      // loss of signal for each criterion
      wr(`LSM_A_LOS_MASK, 8'hFE);
      for (int i = 0; i < 3; i++)
      begin
         wr(`LSM_A_CFG, cf[i]);
         repeat (140) tick(1'b1);
         chk("no_signal_pin", 8'h00, no_signal_pin);
         wr(`LSM_A_LOS_LAT, 8'hFF);
         repeat (zr[i]) tick(1'b0);
         chk("no_signal_pin", 8'h00, no_signal_pin);
         tick(1'b0);
         chk("no_signal_pin", 8'hFF, no_signal_pin);
         chk("int_b", 0, int_b);
         rd(`LSM_A_LOS_STAT, 8'hFF);
         rd(`LSM_A_LOS_LAT, 8'hFF);
         wr(`LSM_A_LOS_LAT, 8'hFF);
         cyc(3);
         chk("int_b", 1, int_b);
         repeat (gd[i] - 8) tick(1'b1);
         chk("no_signal_pin", 8'hFF, no_signal_pin);
         repeat (16) tick(1'b1);
         chk("no_signal_pin", 8'h00, no_signal_pin);
         chk("int_b", 0, int_b);
      end
      // low amplitude: slices keep flowing during loss
      amp_low_in <= 8'hFF;
      pos_slice_in <= 8'hA5;
      neg_slice_in <= 8'h0F;
      cyc(8);
      chk("no_signal_pin", 8'hFF, no_signal_pin);
      chk("pos_slice_out", 8'hA5, pos_slice_out);
      chk("neg_slice_out", 8'h0F, neg_slice_out);
      chk("rail_xor_out", 8'hAA, rail_xor_out);
      amp_low_in <= 8'h00;
      neg_slice_in <= 8'h00;
      repeat (48) tick(1'b1);
      chk("no_signal_pin", 8'h00, no_signal_pin);
      // hardware mode: template 000 picks the short E1 zero run
      hw_mode_pin <= 1'b1;
      template_code_pin <= 3'h0;
      repeat (`LSM_G775_ZRUN) tick(1'b0);
      chk("no_signal_pin", 8'h00, no_signal_pin);
      tick(1'b0);
      chk("no_signal_pin", 8'hFF, no_signal_pin);
      chk("template_sel", 24'h000000, template_sel);
      stop_test();
   end
endmodule : tb_lsm_top
